//--- rtl/sdb_pkg.sv
package sdb_pkg;
  // Character size codes
  localparam logic [2:0] CSZ_5 = 3'h0;
  localparam logic [2:0] CSZ_6 = 3'h1;
  localparam logic [2:0] CSZ_7 = 3'h2;
  localparam logic [2:0] CSZ_8 = 3'h3;
  localparam logic [2:0] CSZ_9 = 3'h7;
  // Reset values
  localparam logic RST_TX_BUF_EMPTY = 1'b1;
  localparam logic RST_TX_COMPLETE = 1'b0;
  localparam logic RST_LINE_IDLE = 1'b1;
  // Receive buffer depth in characters
  localparam int RX_DEPTH = 2;
  // Default baud divider in system clocks per bit
  localparam int BAUD_DIV_DEF = 16;

  typedef struct packed {
    logic [2:0] char_size_code;
    logic parity_enable_bit;
    logic parity_odd_select;
    logic two_stop;
    logic sync_mode;
  } sdb_frame_cfg_s;

  typedef struct packed {
    logic rx_ninth_bit;
    logic frame_error_flag;
    logic overrun_flag;
    logic parity_error_flag;
    logic [7:0] data;
  } sdb_rx_entry_s;

  typedef enum logic [2:0] {
    SDB_IDLE,
    SDB_START,
    SDB_DATA,
    SDB_PARITY,
    SDB_STOP1,
    SDB_STOP2
  } sdb_phase_e;
endpackage

//--- rtl/sdb_rx_fifo.sv
`timescale 1ns/1ps
module sdb_rx_fifo
  import sdb_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic push,
  input sdb_rx_entry_s push_entry,
  input wire logic pop,
  output sdb_rx_entry_s head,
  output logic not_empty,
  output logic full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  sdb_rx_entry_s mem_ff [DEPTH];
  sdb_rx_entry_s nxt_mem [DEPTH];
  logic [AW:0] cnt_ff, nxt_cnt;
  logic [AW-1:0] rd_ff, nxt_rd, wr_ff, nxt_wr;
  logic do_push, do_pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign do_pop = pop && (cnt_ff != '0);
  assign do_push = push && ((cnt_ff != (AW+1)'(DEPTH)) || do_pop);

  always_comb begin
    nxt_mem = mem_ff;
    nxt_cnt = cnt_ff;
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    if (flush) begin
      nxt_cnt = '0;
      nxt_rd = '0;
      nxt_wr = '0;
    end else begin
      if (do_push) begin
        nxt_mem[wr_ff] = push_entry;
        nxt_wr = ptr_inc(wr_ff);
      end
      if (do_pop) begin
        nxt_rd = ptr_inc(rd_ff);
      end
      nxt_cnt = cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      rd_ff <= '0;
      wr_ff <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else begin
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      mem_ff <= nxt_mem;
    end
  end

  assign head = mem_ff[rd_ff];
  assign not_empty = (cnt_ff != '0);
  assign full = (cnt_ff == (AW+1)'(DEPTH));
endmodule

//--- rtl/sdb_serial.sv
`timescale 1ns/1ps
// Contract
// - Buffer-empty flag high while transmit buffer empty, low while it holds a character.
// - Writing transmit data loads the buffer and clears the buffer-empty flag; writes are ignored while the transmitter is disabled.
// - Buffer-empty interrupt requested while flag set and its enable is one.
// - Transmit-complete sets when frame shifted out and buffer is empty.
// - Transmit-complete clears on interrupt service or write of one.
// - Transmit-complete interrupt raised while enabled as the flag becomes set.
// - Parity enable inserts parity bit between last data bit and first stop bit.
// - Transmitter disable waits until shift register and buffer are empty.
// - Disabled transmitter releases the transmit pin to its port function.
// - Receiver enable makes the receive pin the serial input.
// - Synchronous mode uses the external transfer clock as bit clock.
// - After start bit, sample each bit at bit rate and shift it in.
// - Second stop bit ignored; only first stop bit checked.
// - At first stop bit move the frame into the receive buffer.
// - Unused upper data bits read as zero for short characters.
// - Ninth bit and error flags stored per entry; data read advances them.
// - Parity is xor of data bits, inverted for odd parity.
// - Frame sends low start bit, then data least significant bit first.
// - Shift register takes buffered character when idle or right after stop bit.
module sdb_serial
  import sdb_pkg::*;
#(
  parameter int BAUD_DIV = BAUD_DIV_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input sdb_frame_cfg_s cfg,
  input wire logic tx_enable_bit,
  input wire logic rx_enable_bit,
  input wire logic tx_buf_empty_irq_en,
  input wire logic tx_complete_irq_en,
  input wire logic tx_ninth_bit,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic data_rd,
  input wire logic tx_complete_wr_one,
  input wire logic tx_complete_irq_ack,
  input wire logic ext_transfer_clock_pin,
  input wire logic rxd_pin,
  output logic txd_out,
  output logic txd_oe,
  output logic rx_pin_owned,
  output logic tx_buf_empty_flag,
  output logic tx_complete_flag,
  output logic tx_buf_empty_irq,
  output logic tx_complete_irq,
  output logic rx_complete_flag,
  output sdb_rx_entry_s rx_head
);
  localparam int DIVW = $clog2(BAUD_DIV + 1);

  function automatic logic [3:0] data_bits(input logic [2:0] code);
    case (code)
      CSZ_5: data_bits = 4'h5;
      CSZ_6: data_bits = 4'h6;
      CSZ_7: data_bits = 4'h7;
      CSZ_9: data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] mask_bits(input logic [8:0] d, input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1ff >> (4'h9 - n);
    mask_bits = d & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bit clock: internal divider or rising edge of the external clock pin
  logic [DIVW-1:0] div_ff, nxt_div;
  logic xck_ff, nxt_xck;
  logic bit_tick;

  always_comb begin
    nxt_div = (div_ff == DIVW'(BAUD_DIV - 1)) ? '0 : div_ff + DIVW'(1);
    nxt_xck = ext_transfer_clock_pin;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_ff <= '0;
      xck_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      xck_ff <= nxt_xck;
    end
  end

  assign bit_tick = cfg.sync_mode ? (ext_transfer_clock_pin && !xck_ff)
                                  : (div_ff == DIVW'(BAUD_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter
  sdb_phase_e tx_ph_ff, nxt_tx_ph;
  logic [8:0] tx_buf_ff, nxt_tx_buf, tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_cnt_ff, nxt_tx_cnt;
  logic tx_par_ff, nxt_tx_par;
  logic tbe_ff, nxt_tbe, tc_ff, nxt_tc, tc_irq_ff, nxt_tc_irq;
  logic txd_ff, nxt_txd, txen_ff, nxt_txen;
  logic tx_load, tx_done, tx_tail_ff, nxt_tx_tail;

  always_comb begin
    nxt_tx_ph = tx_ph_ff;
    nxt_tx_buf = tx_buf_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tbe = tbe_ff;
    nxt_tc = tc_ff;
    nxt_txd = txd_ff;
    tx_load = 1'b0;
    tx_done = 1'b0;
    nxt_tx_tail = tx_tail_ff;
    if (bit_tick && txen_ff) begin
      nxt_tx_tail = 1'b0;
      case (tx_ph_ff)
        SDB_START: begin
          nxt_txd = 1'b0;
          nxt_tx_ph = SDB_DATA;
          nxt_tx_cnt = '0;
        end
        SDB_DATA: begin
          nxt_txd = tx_sh_ff[0];
          nxt_tx_sh = {1'b0, tx_sh_ff[8:1]};
          nxt_tx_cnt = tx_cnt_ff + 4'h1;
          if (tx_cnt_ff == data_bits(cfg.char_size_code) - 4'h1) begin
            nxt_tx_ph = cfg.parity_enable_bit ? SDB_PARITY : SDB_STOP1;
          end
        end
        SDB_PARITY: begin
          nxt_txd = tx_par_ff;
          nxt_tx_ph = SDB_STOP1;
        end
        SDB_STOP1: begin
          nxt_txd = 1'b1;
          nxt_tx_ph = cfg.two_stop ? SDB_STOP2 : SDB_IDLE;
          nxt_tx_tail = !cfg.two_stop;
        end
        SDB_STOP2: begin
          nxt_txd = 1'b1;
          nxt_tx_ph = SDB_IDLE;
          nxt_tx_tail = 1'b1;
        end
        default: begin
          nxt_txd = 1'b1;
          if (tx_ph_ff == SDB_IDLE && !tbe_ff) begin
            tx_load = 1'b1;
          end
        end
      endcase
      // Last stop bit has now stood a full bit time; a waiting character loads above
      if (tx_tail_ff && tbe_ff) begin
        tx_done = 1'b1;
      end
    end
    if (tx_load) begin
      nxt_tx_sh = mask_bits(tx_buf_ff, data_bits(cfg.char_size_code));
      nxt_tx_par = (^mask_bits(tx_buf_ff, data_bits(cfg.char_size_code)))
                   ^ cfg.parity_odd_select;
      nxt_tx_ph = SDB_START;
      nxt_tbe = 1'b1;
    end
    if (data_wr && txen_ff) begin
      nxt_tx_buf = {tx_ninth_bit, data_wdata};
      nxt_tbe = 1'b0;
    end
    if (tx_complete_wr_one || (tx_complete_irq_ack && tc_ff)) begin
      nxt_tc = 1'b0;
    end
    if (tx_done) begin
      nxt_tc = 1'b1;
    end
  end

  always_comb begin
    nxt_txen = txen_ff;
    if (tx_enable_bit) begin
      nxt_txen = 1'b1;
    end else if (tx_ph_ff == SDB_IDLE && tbe_ff && !tx_load && !tx_tail_ff) begin
      nxt_txen = 1'b0;
    end
    nxt_tc_irq = tx_complete_irq_en && nxt_tc;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_ph_ff <= SDB_IDLE;
      tx_buf_ff <= '0;
      tx_sh_ff <= '0;
      tx_cnt_ff <= '0;
      tx_par_ff <= 1'b0;
      tbe_ff <= RST_TX_BUF_EMPTY;
      tc_ff <= RST_TX_COMPLETE;
      tc_irq_ff <= 1'b0;
      txd_ff <= RST_LINE_IDLE;
      txen_ff <= 1'b0;
      tx_tail_ff <= 1'b0;
    end else begin
      tx_ph_ff <= nxt_tx_ph;
      tx_buf_ff <= nxt_tx_buf;
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_par_ff <= nxt_tx_par;
      tbe_ff <= nxt_tbe;
      tc_ff <= nxt_tc;
      tc_irq_ff <= nxt_tc_irq;
      txd_ff <= nxt_txd;
      txen_ff <= nxt_txen;
      tx_tail_ff <= nxt_tx_tail;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver
  sdb_phase_e rx_ph_ff, nxt_rx_ph;
  logic [8:0] rx_sh_ff, nxt_rx_sh;
  logic [3:0] rx_cnt_ff, nxt_rx_cnt;
  logic rx_perr_ff, nxt_rx_perr, dor_ff, nxt_dor;
  logic rx_push;
  logic rx_full;
  sdb_rx_entry_s rx_entry;
  sdb_rx_entry_s fifo_head;
  logic fifo_ne;

  always_comb begin
    nxt_rx_ph = rx_ph_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_perr = rx_perr_ff;
    nxt_dor = dor_ff;
    rx_push = 1'b0;
    rx_entry = '0;
    if (!rx_enable_bit) begin
      nxt_rx_ph = SDB_IDLE;
      nxt_dor = 1'b0;
    end else if (bit_tick) begin
      case (rx_ph_ff)
        SDB_IDLE: begin
          if (!rxd_pin) begin
            nxt_rx_ph = SDB_DATA;
            nxt_rx_sh = '0;
            nxt_rx_cnt = '0;
            if (rx_full) begin
              nxt_dor = 1'b1;
            end
          end
        end
        SDB_DATA: begin
          nxt_rx_sh[rx_cnt_ff] = rxd_pin;
          nxt_rx_cnt = rx_cnt_ff + 4'h1;
          if (rx_cnt_ff == data_bits(cfg.char_size_code) - 4'h1) begin
            nxt_rx_ph = cfg.parity_enable_bit ? SDB_PARITY : SDB_STOP1;
          end
        end
        SDB_PARITY: begin
          nxt_rx_perr = (^rx_sh_ff) ^ cfg.parity_odd_select ^ rxd_pin;
          nxt_rx_ph = SDB_STOP1;
        end
        default: begin
          // First stop bit ends the frame; a second one is just idle line
          rx_entry.data = rx_sh_ff[7:0];
          rx_entry.rx_ninth_bit = rx_sh_ff[8];
          rx_entry.frame_error_flag = !rxd_pin;
          rx_entry.parity_error_flag = cfg.parity_enable_bit && rx_perr_ff;
          rx_entry.overrun_flag = dor_ff;
          rx_push = !rx_full || data_rd;
          if (rx_push) begin
            nxt_dor = 1'b0;
          end
          nxt_rx_perr = 1'b0;
          nxt_rx_ph = SDB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_ph_ff <= SDB_IDLE;
      rx_sh_ff <= '0;
      rx_cnt_ff <= '0;
      rx_perr_ff <= 1'b0;
      dor_ff <= 1'b0;
    end else begin
      rx_ph_ff <= nxt_rx_ph;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_perr_ff <= nxt_rx_perr;
      dor_ff <= nxt_dor;
    end
  end

  sdb_rx_fifo #(
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .flush(!rx_enable_bit),
    .push(rx_push),
    .push_entry(rx_entry),
    .pop(data_rd),
    .head(fifo_head),
    .not_empty(fifo_ne),
    .full(rx_full)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic rxc_out_ff, tbe_irq_ff, pin_rx_ff, txoe_ff;
  sdb_rx_entry_s head_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rxc_out_ff <= 1'b0;
      tbe_irq_ff <= 1'b0;
      pin_rx_ff <= 1'b0;
      txoe_ff <= 1'b0;
      head_ff <= '0;
    end else begin
      rxc_out_ff <= fifo_ne;
      tbe_irq_ff <= tx_buf_empty_irq_en && nxt_tbe;
      pin_rx_ff <= rx_enable_bit;
      txoe_ff <= nxt_txen;
      head_ff <= fifo_head;
    end
  end

  assign txd_out = txd_ff;
  assign txd_oe = txoe_ff;
  assign rx_pin_owned = pin_rx_ff;
  assign tx_buf_empty_flag = tbe_ff;
  assign tx_complete_flag = tc_ff;
  assign tx_buf_empty_irq = tbe_irq_ff;
  assign tx_complete_irq = tc_irq_ff;
  assign rx_complete_flag = rxc_out_ff;
  assign rx_head = head_ff;
endmodule

//--- test/sdb_remote_model.sv
`timescale 1ns/1ps
module sdb_remote_model (
  input wire logic clk_sys,
  input wire logic txd_line,
  input wire logic [7:0] per,
  input wire logic [3:0] nsamp,
  output logic rxd_pin,
  output logic got_v,
  output logic [11:0] got_frame
);
  int i;
  // Samples mid-bit, so a frame shifted by one clock still decodes
  initial begin
    rxd_pin = 1'b1;
    got_v = 1'b0;
    forever begin
      @(posedge clk_sys);
      got_v <= 1'b0;
      if (txd_line === 1'b0) begin
        got_frame = 12'h000;
        repeat (per / 2) @(posedge clk_sys);
        for (i = 0; i < nsamp; i++) begin
          repeat (per) @(posedge clk_sys);
          got_frame[i] = txd_line;
        end
        got_v <= 1'b1;
      end
    end
  end

  task automatic send(input logic [11:0] f, input int n, input int p);
    int k;
    @(posedge clk_sys);
    rxd_pin <= 1'b0;
    repeat (p) @(posedge clk_sys);
    for (k = 0; k < n; k++) begin
      rxd_pin <= f[k];
      repeat (p) @(posedge clk_sys);
    end
    rxd_pin <= 1'b1;
    repeat (2 * p) @(posedge clk_sys);
  endtask
endmodule

//--- test/sdb_serial_props.sv
`timescale 1ns/1ps
module sdb_serial_props
  import sdb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input sdb_frame_cfg_s cfg,
  input wire logic tx_enable_bit,
  input wire logic rx_enable_bit,
  input wire logic tx_buf_empty_irq_en,
  input wire logic tx_complete_irq_en,
  input wire logic data_wr,
  input wire logic tx_complete_wr_one,
  input wire logic tx_complete_irq_ack,
  input wire logic txd_oe,
  input wire logic rx_pin_owned,
  input wire logic tx_buf_empty_flag,
  input wire logic tx_complete_flag,
  input wire logic tx_buf_empty_irq,
  input wire logic tx_complete_irq,
  input wire logic rx_complete_flag,
  input sdb_rx_entry_s rx_head
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_RESET_STATE: assert property ($rose(rst_b) |-> tx_buf_empty_flag && !tx_complete_flag
    && !txd_oe && !rx_pin_owned) else $error("state after reset wrong");
  AST_WR_CLEARS_EMPTY: assert property (data_wr && txd_oe |=> !tx_buf_empty_flag)
    else $error("write left buffer empty flag set");
  AST_EMPTY_IRQ: assert property (tx_buf_empty_irq_en |=> tx_buf_empty_irq == tx_buf_empty_flag)
    else $error("buffer empty request missing");
  AST_TXC_NEEDS_EMPTY: assert property ($rose(tx_complete_flag) |-> $past(tx_buf_empty_flag))
    else $error("complete set with buffer loaded");
  AST_TXC_CLEAR: assert property ($fell(tx_complete_flag)
    |-> $past(tx_complete_wr_one || tx_complete_irq_ack)) else $error("complete cleared by itself");
  AST_TXC_IRQ: assert property ($rose(tx_complete_flag) && tx_complete_irq_en |=> tx_complete_irq)
    else $error("complete request missing");
  AST_DISABLE_DEFER: assert property ($fell(txd_oe)
    |-> $past(!tx_enable_bit && tx_buf_empty_flag)) else $error("pin released too early");
  AST_RX_OWN: assert property (rx_enable_bit |=> rx_pin_owned)
    else $error("receive pin not taken");
  AST_RX_FLUSH: assert property (!rx_enable_bit |-> ##2 !rx_complete_flag)
    else $error("receive buffer not flushed");
  AST_SHORT_ZERO: assert property (rx_complete_flag && cfg.char_size_code < CSZ_8
    |-> (rx_head.data >> (cfg.char_size_code + 3'h5)) == 8'h00) else $error("upper bits not zero");
endmodule

bind sdb_serial sdb_serial_props u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .cfg(cfg), .tx_enable_bit(tx_enable_bit),
  .rx_enable_bit(rx_enable_bit), .tx_buf_empty_irq_en(tx_buf_empty_irq_en),
  .tx_complete_irq_en(tx_complete_irq_en), .data_wr(data_wr),
  .tx_complete_wr_one(tx_complete_wr_one), .tx_complete_irq_ack(tx_complete_irq_ack),
  .txd_oe(txd_oe), .rx_pin_owned(rx_pin_owned), .tx_buf_empty_flag(tx_buf_empty_flag),
  .tx_complete_flag(tx_complete_flag), .tx_buf_empty_irq(tx_buf_empty_irq),
  .tx_complete_irq(tx_complete_irq), .rx_complete_flag(rx_complete_flag), .rx_head(rx_head)
);

//--- test/tb_sdb_serial.sv
`timescale 1ns/1ps
module tb_sdb_serial;
  import sdb_pkg::*;
  localparam int DIV = 4;
  logic clk_sys, rst_b, tx_enable_bit, rx_enable_bit, tx_buf_empty_irq_en, tx_complete_irq_en;
  logic tx_ninth_bit, data_wr, data_rd, tx_complete_wr_one, tx_complete_irq_ack;
  logic ext_transfer_clock_pin, rxd_pin, txd_out, txd_oe, rx_pin_owned, tx_buf_empty_flag;
  logic tx_complete_flag, tx_buf_empty_irq, tx_complete_irq, rx_complete_flag, got_v, hold_rd;
  logic [7:0] data_wdata, per;
  logic [3:0] nsamp;
  logic [11:0] got_frame;
  sdb_frame_cfg_s cfg;
  sdb_rx_entry_s rx_head;
  logic [11:0] txq[$];
  sdb_rx_entry_s rxq[$];
  int mismatches, check_count, cyc, nb, c;
  int nbt[5] = '{5, 6, 7, 8, 9};
  logic [2:0] code[5] = '{CSZ_5, CSZ_6, CSZ_7, CSZ_8, CSZ_9};

  sdb_serial #(.BAUD_DIV(DIV)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .cfg(cfg), .tx_enable_bit(tx_enable_bit),
    .rx_enable_bit(rx_enable_bit), .tx_buf_empty_irq_en(tx_buf_empty_irq_en),
    .tx_complete_irq_en(tx_complete_irq_en), .tx_ninth_bit(tx_ninth_bit), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rd(data_rd), .tx_complete_wr_one(tx_complete_wr_one),
    .tx_complete_irq_ack(tx_complete_irq_ack), .ext_transfer_clock_pin(ext_transfer_clock_pin),
    .rxd_pin(rxd_pin), .txd_out(txd_out), .txd_oe(txd_oe), .rx_pin_owned(rx_pin_owned),
    .tx_buf_empty_flag(tx_buf_empty_flag), .tx_complete_flag(tx_complete_flag),
    .tx_buf_empty_irq(tx_buf_empty_irq), .tx_complete_irq(tx_complete_irq),
    .rx_complete_flag(rx_complete_flag), .rx_head(rx_head));
  // Released transmit pin reads high through the line's pull-up
  sdb_remote_model u_far (.clk_sys(clk_sys), .txd_line(txd_oe ? txd_out : 1'b1), .per(per),
    .nsamp(nsamp), .rxd_pin(rxd_pin), .got_v(got_v), .got_frame(got_frame));
  assign per = cfg.sync_mode ? 8'h08 : 8'(DIV);
  assign nsamp = 4'(nb + 32'(cfg.parity_enable_bit) + 1);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // External bit clock, period of two internal bit times, to expose the wrong clock source
  initial begin
    ext_transfer_clock_pin = 1'b0;
    forever begin
      repeat (4) @(posedge clk_sys);
      ext_transfer_clock_pin <= ~ext_transfer_clock_pin;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [11:0] frm(input logic [8:0] d, input int n, input logic pe, od);
    logic [8:0] m;
    m = d & ((9'h1 << n) - 9'h1);
    frm = 12'(m) | (12'(pe & (od ^ (^m))) << n) | (12'h1 << (n + 32'(pe)));
  endfunction

  task automatic setc(input int k, input logic sy);
    @(posedge clk_sys);
    cfg <= '{code[k], 1'($urandom), 1'($urandom), 1'($urandom), sy};
    nb = nbt[k];
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic put(input logic [8:0] d);
    int w;
    w = 0;
    while (tx_buf_empty_flag !== 1'b1 && w < 500) begin
      @(negedge clk_sys);
      w++;
    end
    if (w >= 500) begin
      mismatches++;
      $display("BAD %0t buffer never emptied", $time);
    end
    @(posedge clk_sys);
    tx_ninth_bit <= d[8];
    data_wdata <= d[7:0];
    data_wr <= 1'b1;
    txq.push_back(frm(d, nb, cfg.parity_enable_bit, cfg.parity_odd_select));
    @(posedge clk_sys);
    data_wr <= 1'b0;
    @(negedge clk_sys);
    chk(12'(tx_buf_empty_flag), 12'h0);
    @(posedge clk_sys);
  endtask

  task automatic rxf(input logic drop, input logic ovr);
    logic [8:0] d;
    logic pe, bad;
    logic [11:0] f;
    d = 9'($urandom);
    pe = cfg.parity_enable_bit & 1'($urandom);
    bad = 1'($urandom);
    f = frm(d, nb, cfg.parity_enable_bit, cfg.parity_odd_select) ^ (12'(pe) << nb);
    f[nb + 32'(cfg.parity_enable_bit)] = ~bad;
    if (!drop) rxq.push_back(sdb_rx_entry_s'({nb == 9 && d[8], bad, ovr, pe,
      8'(d & ((9'h1 << nb) - 9'h1))}));
    u_far.send(f, nb + 32'(cfg.parity_enable_bit) + 1, 32'(per));
  endtask

  task automatic drain();
    int w;
    w = 0;
    while ((txq.size() > 0 || rxq.size() > 0) && w < 3000) begin
      @(negedge clk_sys);
      w++;
    end
    if (w >= 3000) begin
      mismatches++;
      $display("BAD %0t expected results never arrived", $time);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (got_v === 1'b1) chk(got_frame, txq.pop_front());
  end

  initial begin
    data_rd = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (rx_complete_flag === 1'b1 && !hold_rd) begin
        chk(12'(rx_head), 12'(rxq.pop_front()));
        @(posedge clk_sys);
        data_rd <= 1'b1;
        @(posedge clk_sys);
        data_rd <= 1'b0;
        repeat (2) @(posedge clk_sys);
      end
    end
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    void'($urandom(29));
    {rst_b, tx_enable_bit, rx_enable_bit, tx_buf_empty_irq_en, tx_complete_irq_en} = '0;
    {tx_ninth_bit, data_wr, data_wdata, tx_complete_wr_one, tx_complete_irq_ack} = '0;
    {cfg, hold_rd, mismatches, check_count, nb} = '0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    chk(12'({tx_buf_empty_flag, tx_complete_flag, txd_oe, txd_out}), 12'h9);
    @(posedge clk_sys);
    {tx_enable_bit, rx_enable_bit, tx_buf_empty_irq_en, tx_complete_irq_en} <= 4'hf;
    for (c = 0; c < 5; c++) begin
      setc(c, 1'b0);
      repeat (3) put(9'($urandom));
      drain();
      repeat (20) @(negedge clk_sys);
      chk(12'(tx_complete_flag), 12'h1);
      @(posedge clk_sys);
      if (c[0]) tx_complete_irq_ack <= 1'b1;
      else tx_complete_wr_one <= 1'b1;
      @(posedge clk_sys);
      {tx_complete_irq_ack, tx_complete_wr_one} <= 2'b00;
      repeat (2) @(negedge clk_sys);
      chk(12'(tx_complete_flag), 12'h0);
      repeat (2) rxf(1'b0, 1'b0);
      drain();
    end
    put(9'($urandom));
    put(9'($urandom));
    tx_enable_bit <= 1'b0;
    @(negedge clk_sys);
    chk(12'(txd_oe), 12'h1);
    drain();
    repeat (30) @(negedge clk_sys);
    chk(12'({txd_oe, txd_out}), 12'h1);
    @(posedge clk_sys);
    tx_enable_bit <= 1'b1;
    // Third frame arrives with both entries unread and is lost
    hold_rd = 1'b1;
    rxf(1'b0, 1'b0);
    rxf(1'b0, 1'b0);
    rxf(1'b1, 1'b0);
    hold_rd = 1'b0;
    drain();
    rxf(1'b0, 1'b1);
    drain();
    setc(3, 1'b1);
    put(9'($urandom));
    rxf(1'b0, 1'b0);
    drain();
    hold_rd = 1'b1;
    rxf(1'b1, 1'b0);
    @(posedge clk_sys);
    rx_enable_bit <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(12'(rx_complete_flag), 12'h0);
    conclude();
  end
endmodule
